// ### inc/nv_pkg.sv
// Shared constants, commands and carriers for the nonvolatile write controller
package nv_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 100;
	localparam int WIN_US = 120;
	localparam int WIN_CYC = WIN_US * CLK_MHZ;
	localparam int PWRUP_MS = 5;
	localparam int PWRUP_CYC = PWRUP_MS * 1000 * CLK_MHZ;
	localparam int FL_TMO_US = 1000;
	localparam int FL_TMO_CYC = FL_TMO_US * CLK_MHZ;
	// Geometry
	localparam int ADDR_W = 15;
	localparam int PAGE_BYTES = 64;
	localparam int IDX_W = 6;
	localparam int PAGE_W = 9;
	localparam int PAGE_LSB = 6;
	localparam int OTP_SEL_BIT = 6;
	// Command addresses (low 12 address bits) and data codes
	localparam logic [11:0] CMD_ADDR1 = 12'h555;
	localparam logic [11:0] CMD_ADDR2 = 12'haaa;
	localparam logic [7:0] CMD_D1 = 8'haa;
	localparam logic [7:0] CMD_D2 = 8'h55;
	localparam logic [7:0] CMD_PROG = 8'ha0;
	localparam logic [7:0] CMD_EXT = 8'h80;
	localparam logic [7:0] CMD_OTP = 8'h90;
	localparam logic [7:0] CMD_OFF = 8'h20;
	localparam logic [7:0] CMD_SECT = 8'h30;
	localparam logic [7:0] CMD_BULK = 8'h10;
	localparam logic [7:0] ERASED = 8'hff;
	// Status byte layout
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ERR_BIT = 5;
	// Decoded command sequences
	typedef enum logic [2:0] {
		C_NONE = 3'h0,
		C_PROG = 3'h1,
		C_OTP = 3'h2,
		C_OFF = 3'h3,
		C_SECT = 3'h4,
		C_BULK = 3'h5
	} cmd_t;
	// One byte towards the EEPROM cells
	typedef struct packed {
		logic valid;
		logic [PAGE_W-1:0] page;
		logic [IDX_W-1:0] idx;
		logic [7:0] data;
	} eeWr_t;
	// One flash program or erase launch
	typedef struct packed {
		logic prog;
		logic erase;
		logic bulk;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} flOp_t;
endpackage

// ### design/cmd_seq.sv
// Command sequence recogniser with an inter-write gap limit
`timescale 1ns/10ps
module cmd_seq #(
	parameter int WIN = nv_pkg::WIN_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write event from the bus
	input wire logic wrEvt,
	input wire logic [nv_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] data,
	// Decoder results
	output logic consumed,
	output nv_pkg::cmd_t cmd,
	output logic active
);
	localparam int GW = $clog2(WIN + 1);
	// One-hot sequence steps
	typedef enum logic [5:0] {
		S0 = 6'h01, S1 = 6'h02, S2 = 6'h04, S3 = 6'h08, S4 = 6'h10, S5 = 6'h20
	} step_t;
	step_t stepFf, nxt_step;
	logic [GW-1:0] gapFf; // Cycles since the last write
	logic match;
	wire a1 = addr[11:0] == nv_pkg::CMD_ADDR1;
	wire a2 = addr[11:0] == nv_pkg::CMD_ADDR2;
	wire gapOut = gapFf >= GW'(WIN - 1);
	assign consumed = wrEvt & match;
	assign active = stepFf != S0;
	// Next step and decoded command
	always_comb
	begin
		match = 1'b0;
		cmd = nv_pkg::C_NONE;
		nxt_step = S0;
		case (stepFf)
			S0: match = a1 && data == nv_pkg::CMD_D1;
			S1: match = a2 && data == nv_pkg::CMD_D2;
			S2: match = a1 && (data == nv_pkg::CMD_PROG || data == nv_pkg::CMD_EXT
				|| data == nv_pkg::CMD_OTP);
			S3: match = a1 && data == nv_pkg::CMD_D1;
			S4: match = a2 && data == nv_pkg::CMD_D2;
			S5: match = (a1 && (data == nv_pkg::CMD_OFF || data == nv_pkg::CMD_BULK))
				|| data == nv_pkg::CMD_SECT;
			default: match = 1'b0;
		endcase
		if (match)
		begin
			case (stepFf)
				S0: nxt_step = S1;
				S1: nxt_step = S2;
				S2: nxt_step = data == nv_pkg::CMD_EXT ? S3 : S0;
				S3: nxt_step = S4;
				S4: nxt_step = S5;
				default: nxt_step = S0;
			endcase
			if (stepFf == S2 && data == nv_pkg::CMD_PROG)
				cmd = nv_pkg::C_PROG;
			else if (stepFf == S2 && data == nv_pkg::CMD_OTP)
				cmd = nv_pkg::C_OTP;
			else if (stepFf == S5 && data == nv_pkg::CMD_OFF)
				cmd = nv_pkg::C_OFF;
			else if (stepFf == S5 && data == nv_pkg::CMD_BULK)
				cmd = nv_pkg::C_BULK;
			else if (stepFf == S5)
				cmd = nv_pkg::C_SECT;
			if (!wrEvt)
				cmd = nv_pkg::C_NONE;
		end
	end
	// Step register; a stale sequence is dropped after the gap limit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stepFf <= S0;
			gapFf <= '0;
		end
		else if (wrEvt)
		begin
			stepFf <= nxt_step;
			gapFf <= '0;
		end
		else
		begin
			if (gapOut)
				stepFf <= S0;
			if (!gapOut)
				gapFf <= gapFf + 1'b1;
		end
	end
endmodule

// ### design/ee_flash_ctrl.sv
// EEPROM write control, write lock, one-time row and flash status reporting
// Notes on behaviour
// - EEPROM byte write taken on select plus strobe
// - Storage starts after 120 us without writes
// - Busy shown by polling, toggle and ready pin
// - 64-byte volatile buffer committed in one storage
// - Any order within page, low six bits index
// - Page commit begins 120 us after last write
// - Locked device takes data only after unlock
// - Lock state nonvolatile, cleared only by disable
// - Enable sequence may be followed by data directly
// - Ready pin low from first EEPROM command write
// - Lock commands report by toggle or pin
// - Sequences span pages within 120 us gaps
// - One-time row byte written once after enable
// - One-time row refused while locked
// - Flash programs only zeros, after command sequence
// - Program polling shows inverted bit seven
// - Error on timeout or zero-to-one attempt
// - Erase polling reads zero; error on timeout
// - Toggle bit flips per busy read
// - EEPROM writes inhibited 5 ms after power-up
`timescale 1ns/10ps
module ee_flash_ctrl #(
	parameter int WIN_CYC = nv_pkg::WIN_CYC,
	parameter int PWRUP_CYC = nv_pkg::PWRUP_CYC,
	parameter int FL_TMO_CYC = nv_pkg::FL_TMO_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host bus
	input wire logic [nv_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic eeSectorSelect,
	input wire logic flashSectorSelect,
	output logic [7:0] rdData,
	// Cell arrays
	input wire logic [7:0] eeCellData,
	input wire logic [7:0] flashCellData,
	input wire logic eeCellDone,
	input wire logic flashCellDone,
	output nv_pkg::eeWr_t eeWr,
	output nv_pkg::eeWr_t otpWr,
	output nv_pkg::flOp_t flOp,
	// Lock cell
	input wire logic lockNvIn,
	output logic lockWr,
	output logic lockState,
	// Status pin
	output logic readyBusyPin
);
	localparam int WW = $clog2(WIN_CYC + 1);
	localparam int PW = $clog2(PWRUP_CYC + 1);
	localparam int TW = $clog2(FL_TMO_CYC + 1);
	// EEPROM storage states
	typedef enum logic [3:0] {
		EE_IDLE = 4'h1, EE_COLLECT = 4'h2, EE_STORE = 4'h4, EE_WAIT = 4'h8
	} ee_t;
	// Flash operation states
	typedef enum logic [2:0] {
		FL_IDLE = 3'h1, FL_PROG = 3'h2, FL_ERASE = 3'h4
	} fl_t;

	// Status byte builder
	function automatic logic [7:0] statByte(input logic poll, input logic tog, input logic err);
		statByte = '0;
		statByte[nv_pkg::POLL_BIT] = poll;
		statByte[nv_pkg::TOGGLE_BIT] = tog;
		statByte[nv_pkg::ERR_BIT] = err;
	endfunction

	ee_t eeState, nxt_ee;
	fl_t flState, nxt_fl;
	logic [7:0] bufFf [nv_pkg::PAGE_BYTES]; // Page buffer
	logic [nv_pkg::PAGE_BYTES-1:0] loadedFf; // Entries holding data
	logic [nv_pkg::PAGE_BYTES-1:0] otpUsedFf; // Row bytes already written
	logic [nv_pkg::PAGE_W-1:0] pageFf; // Page of the buffered data
	logic anyLoadedFf; // Buffer holds at least one byte
	logic [WW-1:0] winCnt; // Inactivity window
	logic [PW-1:0] pwrCnt; // Power-up inhibit
	logic [TW-1:0] tmoCnt; // Flash operation timeout
	logic [nv_pkg::IDX_W-1:0] streamIdx; // Buffer entry being committed
	logic lockFf, lockLoadedFf, unlockFf, pendLockFf, pendValFf;
	logic otpArmedFf, progArmedFf, flErrFf, progBit7Ff, lastBit7Ff, toggleFf;
	logic eeConsumed, eeSeqActive, flConsumed;
	nv_pkg::cmd_t eeCmd, flCmd;

	// Decode of bus events
	wire eeWrEvt = wrStb & eeSectorSelect;
	wire flWrEvt = wrStb & flashSectorSelect;
	wire inhibit = pwrCnt != '0;
	wire [nv_pkg::PAGE_W-1:0] wrPage = addr[nv_pkg::ADDR_W-1:nv_pkg::PAGE_LSB];
	wire [nv_pkg::IDX_W-1:0] wrIdx = addr[nv_pkg::IDX_W-1:0];
	wire eeOpen = eeState == EE_IDLE || eeState == EE_COLLECT;
	wire pageOk = !anyLoadedFf || wrPage == pageFf;
	wire dataWr = eeWrEvt & ~eeConsumed & ~inhibit & eeOpen & ~otpArmedFf;
	wire eeAccept = dataWr & (~lockFf | unlockFf) & pageOk;
	wire lockOn = eeCmd == nv_pkg::C_PROG && !inhibit && eeOpen;
	wire lockOff = eeCmd == nv_pkg::C_OFF && !inhibit && eeOpen;
	wire cmdTake = lockOn | lockOff;
	wire winDone = eeState == EE_COLLECT && winCnt == '0;
	wire storeEnd = eeState == EE_STORE && streamIdx == nv_pkg::IDX_W'(nv_pkg::PAGE_BYTES - 1);
	wire otpTry = otpArmedFf & eeWrEvt & ~eeConsumed;
	wire otpOk = otpTry & ~addr[nv_pkg::OTP_SEL_BIT] & ~otpUsedFf[wrIdx] & ~lockFf & ~inhibit;
	wire progTry = progArmedFf & flWrEvt & ~flConsumed & flState == FL_IDLE;
	wire badBits = |(wrData & ~flashCellData);
	wire progGo = progTry & ~badBits;
	wire eraseGo = (flCmd == nv_pkg::C_SECT || flCmd == nv_pkg::C_BULK) && flState == FL_IDLE;
	wire tmoHit = flState != FL_IDLE && tmoCnt == '0 && !flashCellDone;
	wire eeBusy = eeState != EE_IDLE;
	wire flBusy = flState != FL_IDLE;
	wire anyBusy = eeBusy | flBusy;
	wire busyRead = rdStb & (eeSectorSelect | flashSectorSelect) & anyBusy;
	wire pinBusy = eeBusy | eeSeqActive | eeConsumed | flBusy;
	wire [7:0] eeStat = statByte(~lastBit7Ff, toggleFf, 1'b0);
	wire [7:0] flStat = statByte(flState == FL_ERASE ? 1'b0 : ~progBit7Ff, toggleFf, flErrFf);

	// Sequence recognisers for the two arrays
	cmd_seq #(.WIN(WIN_CYC)) eeSeq (
		.clk(clk),
		.rst(rst),
		.wrEvt(eeWrEvt),
		.addr(addr),
		.data(wrData),
		.consumed(eeConsumed),
		.cmd(eeCmd),
		.active(eeSeqActive)
	);
	cmd_seq #(.WIN(WIN_CYC)) flSeq (
		.clk(clk),
		.rst(rst),
		.wrEvt(flWrEvt),
		.addr(addr),
		.data(wrData),
		.consumed(flConsumed),
		.cmd(flCmd),
		.active()
	);

	// EEPROM state transitions
	always_comb
	begin
		nxt_ee = eeState;
		case (eeState)
			EE_IDLE: if (eeAccept | cmdTake) nxt_ee = EE_COLLECT;
			EE_COLLECT: if (winDone) nxt_ee = EE_STORE;
			EE_STORE: if (storeEnd) nxt_ee = EE_WAIT;
			EE_WAIT: if (eeCellDone) nxt_ee = EE_IDLE;
			default: nxt_ee = EE_IDLE;
		endcase
	end

	// Flash state transitions
	always_comb
	begin
		nxt_fl = flState;
		case (flState)
			FL_IDLE: if (progGo) nxt_fl = FL_PROG; else if (eraseGo) nxt_fl = FL_ERASE;
			FL_PROG, FL_ERASE: if (flashCellDone | tmoHit) nxt_fl = FL_IDLE;
			default: nxt_fl = FL_IDLE;
		endcase
	end

	// State registers and power-up inhibit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			eeState <= EE_IDLE;
			flState <= FL_IDLE;
			pwrCnt <= PW'(PWRUP_CYC);
		end
		else
		begin
			eeState <= nxt_ee;
			flState <= nxt_fl;
			if (inhibit)
				pwrCnt <= pwrCnt - 1'b1;
		end
	end

	// Inactivity window restarted by each accepted write
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			winCnt <= '0;
		else if (eeAccept | cmdTake)
			winCnt <= WW'(WIN_CYC - 1);
		else if (winCnt != '0)
			winCnt <= winCnt - 1'b1;
	end

	// Page buffer fill and drain
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			loadedFf <= '0;
			anyLoadedFf <= 1'b0;
			pageFf <= '0;
			lastBit7Ff <= 1'b0;
			streamIdx <= '0;
			for (int i = 0; i < nv_pkg::PAGE_BYTES; i++)
				bufFf[i] <= '0;
		end
		else
		begin
			if (eeAccept)
			begin
				bufFf[wrIdx] <= wrData;
				loadedFf[wrIdx] <= 1'b1;
				anyLoadedFf <= 1'b1;
				pageFf <= wrPage;
				lastBit7Ff <= wrData[7];
			end
			if (eeState == EE_STORE)
			begin
				loadedFf[streamIdx] <= 1'b0;
				streamIdx <= streamIdx + 1'b1;
			end
			if (eeState == EE_WAIT && eeCellDone)
				anyLoadedFf <= 1'b0;
		end
	end

	// Committed bytes towards the cells
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			eeWr <= '0;
		else
		begin
			eeWr.valid <= eeState == EE_STORE && loadedFf[streamIdx];
			eeWr.page <= pageFf;
			eeWr.idx <= streamIdx;
			eeWr.data <= bufFf[streamIdx];
		end
	end

	// Write lock: loaded from its cell after reset, changed via storage
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lockFf <= 1'b0;
			lockLoadedFf <= 1'b0;
			unlockFf <= 1'b0;
			pendLockFf <= 1'b0;
			pendValFf <= 1'b0;
			lockWr <= 1'b0;
		end
		else
		begin
			lockLoadedFf <= 1'b1;
			if (!lockLoadedFf)
				lockFf <= lockNvIn;
			lockWr <= winDone & pendLockFf;
			if (winDone) // Cleared first, so a command in the same cycle wins
			begin
				unlockFf <= 1'b0;
				pendLockFf <= 1'b0;
				if (pendLockFf)
					lockFf <= pendValFf;
			end
			if (lockOn)
			begin
				unlockFf <= 1'b1;
				pendLockFf <= pendLockFf | ~lockFf;
				pendValFf <= 1'b1;
			end
			if (lockOff)
			begin
				pendLockFf <= 1'b1;
				pendValFf <= 1'b0;
			end
		end
	end
	assign lockState = lockFf;

	// One-time row: armed by command, each byte once, never when locked
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			otpArmedFf <= 1'b0;
			otpUsedFf <= '0;
			otpWr <= '0;
		end
		else
		begin
			otpWr.valid <= otpOk;
			otpWr.page <= '0;
			otpWr.idx <= wrIdx;
			otpWr.data <= wrData;
			if (otpTry)
				otpArmedFf <= 1'b0;
			if (eeCmd == nv_pkg::C_OTP && !lockFf)
				otpArmedFf <= 1'b1;
			if (otpOk)
				otpUsedFf[wrIdx] <= 1'b1;
		end
	end

	// Flash launch, timeout and error flag
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			progArmedFf <= 1'b0;
			flErrFf <= 1'b0;
			progBit7Ff <= 1'b0;
			tmoCnt <= '0;
			flOp <= '0;
		end
		else
		begin
			flOp.prog <= progGo;
			flOp.erase <= eraseGo;
			flOp.bulk <= flCmd == nv_pkg::C_BULK;
			flOp.addr <= addr;
			flOp.data <= eraseGo ? nv_pkg::ERASED : wrData;
			if (progTry)
				progArmedFf <= 1'b0;
			if (flCmd == nv_pkg::C_PROG)
			begin
				progArmedFf <= 1'b1;
				flErrFf <= 1'b0;
			end
			if (eraseGo)
				flErrFf <= 1'b0;
			if (progGo)
				progBit7Ff <= wrData[7];
			if (progGo | eraseGo)
				tmoCnt <= TW'(FL_TMO_CYC - 1);
			else if (tmoCnt != '0)
				tmoCnt <= tmoCnt - 1'b1;
			if ((progTry & badBits) | tmoHit)
				flErrFf <= 1'b1;
		end
	end

	// Read data: status while busy or after a flash error, cell contents otherwise
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdData <= '0;
			toggleFf <= 1'b0;
		end
		else
		begin
			if (busyRead)
				toggleFf <= ~toggleFf;
			if (rdStb && eeSectorSelect)
				rdData <= eeBusy ? eeStat : eeCellData;
			else if (rdStb && flashSectorSelect)
				rdData <= (flBusy | flErrFf) ? flStat : flashCellData;
			else
				rdData <= '0;
		end
	end

	// Ready/busy pin, low while any internal cycle or lock command runs
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			readyBusyPin <= 1'b1;
		else
			readyBusyPin <= ~pinBusy;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_INHIBIT: assert property (inhibit |=> eeState == EE_IDLE && !otpWr.valid)
		else $error("EEPROM write taken during power-up inhibit");
	AST_WIN_EXPIRE: assert property (winDone |=> eeState == EE_STORE)
		else $error("storage did not start at window expiry");
	AST_WIN_RESTART: assert property (eeAccept |=> winCnt == WW'(WIN_CYC - 1))
		else $error("window not restarted by accepted write");
	AST_BUF_LOAD: assert property (eeAccept |=> bufFf[$past(wrIdx)] == $past(wrData))
		else $error("page buffer entry not loaded");
	AST_LOCK_REFUSE: assert property (lockFf && !unlockFf |-> !eeAccept)
		else $error("locked EEPROM took data without unlock");
	AST_OTP_LOCK: assert property (otpWr.valid |-> !$past(lockFf))
		else $error("one-time row written while locked");
	AST_CMD_BUSY: assert property (eeConsumed |=> !readyBusyPin)
		else $error("ready pin not low after command write");
	AST_POLL_INV: assert property (rdStb && flashSectorSelect && !eeSectorSelect
		&& flState == FL_PROG |=> rdData[7] == ~progBit7Ff)
		else $error("program polling bit not inverted");
	AST_ERASE_POLL: assert property (rdStb && flashSectorSelect && !eeSectorSelect
		&& flState == FL_ERASE |=> rdData[7] == 1'b0)
		else $error("erase polling bit not zero");
	AST_TOGGLE: assert property (busyRead |=> toggleFf != $past(toggleFf))
		else $error("toggle bit did not flip on busy read");
	AST_PROG_ZERO: assert property (progTry && badBits |=> !flOp.prog && flErrFf)
		else $error("zero-to-one program not refused");
endmodule

// ### tb/cell_model.sv
// Behavioural EEPROM, flash and lock cells behind the controller
`timescale 1ns/10ps
module cell_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Controller side
	input wire logic [14:0] addr,
	input wire nv_pkg::eeWr_t eeWr,
	input wire nv_pkg::eeWr_t otpWr,
	input wire nv_pkg::flOp_t flOp,
	input wire logic lockWr,
	input wire logic lockState,
	// Bench controls
	input wire logic slow,
	input wire logic holdFlash,
	// Cell answers
	output logic [7:0] eeCellData,
	output logic [7:0] flashCellData,
	output logic eeCellDone,
	output logic flashCellDone,
	output logic lockNvIn
);
	logic [7:0] eeMem [64]; // EEPROM cells by index
	logic [7:0] flMem [256]; // Flash cells, low address bits
	logic [8:0] eeCnt; // Storage time left
	logic [8:0] flCnt; // Flash operation time left
	logic lockPend; // Lock cell write due
	nv_pkg::flOp_t flHeld; // Flash operation in flight
	// Contents seen at the current address
	assign eeCellData = eeMem[addr[5:0]];
	assign flashCellData = flMem[addr[7:0]];
	// Lock cell and erased flash at power-up
	initial
	begin
		lockNvIn = 1'h0;
		for (int i = 0; i < 256; i++)
			flMem[i] = 8'hff;
	end
	// Lock cell survives reset
	always @(posedge clk)
	begin
		lockPend <= lockWr;
		if (lockPend)
			lockNvIn <= lockState;
	end
	// Storage and flash timers; a held flash op never finishes
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			eeCnt <= 9'h0;
			flCnt <= 9'h0;
			eeCellDone <= 1'h0;
			flashCellDone <= 1'h0;
		end
		else
		begin
			eeCellDone <= (eeCnt == 9'h1);
			flashCellDone <= (flCnt == 9'h1);
			if (eeWr.valid)
				eeMem[eeWr.idx] <= eeWr.data;
			if (eeWr.valid || otpWr.valid || lockWr)
				eeCnt <= slow ? 9'hc8 : 9'h46;
			else if (eeCnt != 9'h0)
				eeCnt <= eeCnt - 9'h1;
			if ((flOp.prog || flOp.erase) && !holdFlash)
			begin
				flCnt <= slow ? 9'h28 : 9'h14;
				flHeld <= flOp;
			end
			else if (flCnt != 9'h0)
				flCnt <= flCnt - 9'h1;
			// Erase sets ones, programming only clears bits
			if (flCnt == 9'h1 && flHeld.erase)
				for (int i = 0; i < 256; i++)
					flMem[i] <= 8'hff;
			else if (flCnt == 9'h1)
				flMem[flHeld.addr[7:0]] <= flMem[flHeld.addr[7:0]] & flHeld.data;
		end
	end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the EEPROM write controller and flash status
`timescale 1ns/10ps
`define CHK(name, exp, got) \
	begin \
		checksDone++; \
		if ((got) !== (exp)) \
		begin \
			miscompares++; \
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
		end \
	end
module tb_top;
	localparam int WIN = 20;
	localparam int PWR = 10;
	localparam int TMO = 50;
	// Bus and cell signals
	logic clk, rst, wrStb, rdStb, eeSel, flSel, slow, holdFlash;
	logic [14:0] addr;
	logic [7:0] wrData, rdData, eeCellData, flashCellData, v, w;
	logic eeCellDone, flashCellDone, lockNvIn, lockWr, lockState, readyBusyPin;
	nv_pkg::eeWr_t eeWr, otpWr, otpLast;
	nv_pkg::flOp_t flOp, flLast;
	// Bookkeeping
	int miscompares, checksDone, cyc, eeCnt, otpCnt, flCnt, eeFirst, lastWr;
	logic [7:0] eeSeen [64];
	logic [8:0] eePg; // Page of the last committed byte
	ee_flash_ctrl #(.WIN_CYC(WIN), .PWRUP_CYC(PWR), .FL_TMO_CYC(TMO)) u_dut (.clk(clk),
		.rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
		.eeSectorSelect(eeSel), .flashSectorSelect(flSel), .rdData(rdData),
		.eeCellData(eeCellData), .flashCellData(flashCellData), .eeCellDone(eeCellDone),
		.flashCellDone(flashCellDone), .eeWr(eeWr), .otpWr(otpWr), .flOp(flOp),
		.lockNvIn(lockNvIn), .lockWr(lockWr), .lockState(lockState),
		.readyBusyPin(readyBusyPin));
	cell_model u_cells (.clk(clk), .rst(rst), .addr(addr), .eeWr(eeWr), .otpWr(otpWr),
		.flOp(flOp), .lockWr(lockWr), .lockState(lockState), .slow(slow),
		.holdFlash(holdFlash), .eeCellData(eeCellData), .flashCellData(flashCellData),
		.eeCellDone(eeCellDone), .flashCellDone(flashCellDone), .lockNvIn(lockNvIn));
	// Clock
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Output capture and hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (eeWr.valid === 1'h1)
		begin
			eeCnt++;
			eeSeen[eeWr.idx] = eeWr.data;
			eePg = eeWr.page;
			if (eeFirst < 0)
				eeFirst = cyc;
		end
		if (otpWr.valid === 1'h1)
		begin
			otpCnt++;
			otpLast = otpWr;
		end
		if (flOp.prog === 1'h1 || flOp.erase === 1'h1)
		begin
			flCnt++;
			flLast = flOp;
		end
		if (cyc == 20000)
		begin
			miscompares++;
			completeRun();
		end
	end
	// Counts and verdict
	task automatic completeRun();
		$display("Checks %0d, mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One write cycle
	task automatic wr(input logic ee, input logic [14:0] a, input logic [7:0] d);
		@(posedge clk);
		wrStb <= 1'h1;
		eeSel <= ee;
		flSel <= !ee;
		addr <= a;
		wrData <= d;
		@(posedge clk);
		lastWr = cyc;
		wrStb <= 1'h0;
		eeSel <= 1'h0;
		flSel <= 1'h0;
	endtask
	// One read cycle, data taken in the following cycle
	task automatic rd(input logic ee, input logic [14:0] a, output logic [7:0] d);
		@(posedge clk);
		rdStb <= 1'h1;
		eeSel <= ee;
		flSel <= !ee;
		addr <= a;
		@(posedge clk);
		rdStb <= 1'h0;
		eeSel <= 1'h0;
		flSel <= 1'h0;
		#1;
		d = rdData;
	endtask
	// Three-write and six-write command sequences
	task automatic cmd3(input logic ee, input logic [7:0] d);
		wr(ee, 15'h555, 8'haa);
		wr(ee, 15'haaa, 8'h55);
		wr(ee, 15'h555, d);
	endtask
	task automatic cmd6(input logic ee, input logic [7:0] d, input logic [14:0] a);
		cmd3(ee, 8'h80);
		wr(ee, 15'h555, 8'haa);
		wr(ee, 15'haaa, 8'h55);
		wr(ee, a, d);
	endtask
	// Bounded wait for the ready pin
	task automatic waitReady();
		repeat (3) @(posedge clk);
		for (int i = 0; i < 400 && readyBusyPin !== 1'h1; i++)
			@(posedge clk);
		#1;
		`CHK("readyBusyPin", 1'h1, readyBusyPin)
	endtask
	// Page fill in mixed order, one stray page, busy status reads
	task automatic pageWrite();
		eeFirst = -1;
		wr(1'h1, 15'h02bf, 8'h81);
		wr(1'h1, 15'h0311, 8'h55);
		wr(1'h1, 15'h0280, 8'h42);
		wr(1'h1, 15'h0285, 8'h99);
		rd(1'h1, 15'h0285, v);
		rd(1'h1, 15'h0285, w);
		`CHK("pollBit", 1'h0, v[7])
		`CHK("toggleBit", ~v[6], w[6])
		repeat (WIN + 100) @(posedge clk);
		#1;
		`CHK("pageCount", 3, eeCnt)
		`CHK("pageBits", 9'h00a, eePg)
		`CHK("idx3f", 8'h81, eeSeen[6'h3f])
		`CHK("idx00", 8'h42, eeSeen[6'h00])
		`CHK("idx05", 8'h99, eeSeen[6'h05])
		`CHK("window", 1'h1, eeFirst >= lastWr + WIN && eeFirst <= lastWr + WIN + 70)
		`CHK("busyPin", 1'h0, readyBusyPin)
		waitReady();
	endtask
	// Lock enable directly followed by data
	task automatic lockOn();
		wr(1'h1, 15'h555, 8'haa);
		repeat (2) @(posedge clk);
		#1;
		`CHK("busyFirstCmd", 1'h0, readyBusyPin)
		wr(1'h1, 15'haaa, 8'h55);
		wr(1'h1, 15'h555, 8'ha0);
		wr(1'h1, 15'h0123, 8'h3c);
		rd(1'h1, 15'h0123, v);
		rd(1'h1, 15'h0123, w);
		`CHK("lockToggle", ~v[6], w[6])
		repeat (WIN + 100) @(posedge clk);
		#1;
		`CHK("lockOn", 1'h1, lockState)
		`CHK("dataAfterEnable", 8'h3c, eeSeen[6'h23])
		waitReady();
	endtask
	// Locked: plain data and row writes refused, unlocked data taken
	task automatic lockedWrites();
		wr(1'h1, 15'h0200, 8'h11);
		cmd3(1'h1, 8'h90);
		wr(1'h1, 15'h0007, 8'hc3);
		repeat (WIN + 100) @(posedge clk);
		`CHK("lockedCount", 4, eeCnt)
		`CHK("lockedRow", 0, otpCnt)
		waitReady();
		cmd3(1'h1, 8'ha0);
		wr(1'h1, 15'h0201, 8'h77);
		repeat (WIN + 100) @(posedge clk);
		`CHK("unlockedData", 8'h77, eeSeen[6'h01])
		waitReady();
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		#1;
		`CHK("lockKept", 1'h1, lockState)
		repeat (PWR + 2) @(posedge clk);
	endtask
	// Lock disable, then one-time row written once
	task automatic lockOffRow();
		slow <= 1'h0;
		cmd6(1'h1, 8'h20, 15'h555);
		repeat (WIN + 10) @(posedge clk);
		waitReady();
		`CHK("lockOff", 1'h0, lockState)
		cmd3(1'h1, 8'h90);
		wr(1'h1, 15'h0007, 8'hc3);
		repeat (3) @(posedge clk);
		`CHK("rowCount", 1, otpCnt)
		`CHK("rowByte", {1'h1, 9'h0, 6'h07, 8'hc3}, otpLast)
		cmd3(1'h1, 8'h90);
		wr(1'h1, 15'h0007, 8'h3c);
		repeat (3) @(posedge clk);
		`CHK("rowOnce", 1, otpCnt)
		waitReady();
	endtask
	// Flash program, bad program, erase timeout, bulk erase
	task automatic flashOps();
		slow <= 1'h1;
		cmd3(1'h0, 8'ha0);
		wr(1'h0, 15'h0042, 8'h5a);
		rd(1'h0, 15'h0042, v);
		`CHK("progPoll", 2'h2, {v[7], v[5]})
		`CHK("progOp", {1'h1, 2'h0, 15'h0042, 8'h5a}, flLast)
		repeat (50) @(posedge clk);
		rd(1'h0, 15'h0042, v);
		`CHK("progDone", 8'h5a, v)
		cmd3(1'h0, 8'ha0);
		wr(1'h0, 15'h0042, 8'hff);
		rd(1'h0, 15'h0042, v);
		`CHK("zeroToOne", 1'h1, v[5])
		`CHK("noBadProg", 1, flCnt)
		holdFlash <= 1'h1;
		cmd6(1'h0, 8'h30, 15'h0040);
		rd(1'h0, 15'h0041, v);
		`CHK("erasePoll", 1'h0, v[7])
		repeat (TMO + 10) @(posedge clk);
		rd(1'h0, 15'h0041, v);
		`CHK("eraseTmo", 1'h1, v[5])
		holdFlash <= 1'h0;
		cmd6(1'h0, 8'h10, 15'h555);
		repeat (3) @(posedge clk);
		`CHK("bulkOp", 2'h3, {flLast.erase, flLast.bulk})
		repeat (50) @(posedge clk);
		rd(1'h0, 15'h0042, v);
		`CHK("erased", 8'hff, v)
	endtask
	// Main sequence
	initial
	begin
		rst = 1'h1;
		{wrStb, rdStb, eeSel, flSel, holdFlash} = 5'h0;
		slow = 1'h1;
		addr = 15'h0;
		wrData = 8'h0;
		{miscompares, checksDone, cyc, eeCnt, otpCnt, flCnt} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		wr(1'h1, 15'h0100, 8'h12);
		#1;
		`CHK("resetRead", 8'h00, rdData)
		`CHK("resetLock", 1'h0, lockState)
		repeat (WIN + 100) @(posedge clk);
		#1;
		`CHK("inhibit", 0, eeCnt)
		pageWrite();
		lockOn();
		lockedWrites();
		lockOffRow();
		flashOps();
		completeRun();
	end
endmodule
